// ===== rtl/sdcr_control_regs.sv
/*
  synthesizer divider control: serial register load, reference divider,
  phase error measurement, lock detect, fast-lock timer and output mux.
  assumes pins arrive asynchronous to clock; the feedback divider itself
  lives outside and presents its output on feedbackIn.
*/
//
// Overview of operation
// - select code 01 loads reference divider register
// - select code 11 loads noise spur register
// - load control picks timer or modulus
// - wide bandwidth for timer comparison cycles
// - three bits pick output mux source
// - lock after enough successive errors below 15ns
// - lock holds until new channel or 30ns
// - precision bit picks 24 or 40 cycles
// - reference divided by four-bit ratio 1-15
// - modulus goes live on next feedback write
// - counter reset bit holds counters reset
// - three-state bit floats the charge pump
// - power-down bit keeps register contents
// - power-down resets counters, pump, lock detect
// - polarity bit sets phase detector sense
// - four bits drive charge pump current
// - doubler bit makes both reference edges active
// - dither only in lowest spur mode
// - select code 00 loads feedback divider register
// - fast lock raises pump current sixteen fold
// - mux code 110 shows fast-lock switch
// - feedback write with top bit starts fast lock
`timescale 1ns/1ps
`include "sdcr_params.svh"
module sdcr_control_regs (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // three-wire programming pins
  input wire logic serialClk,
  input wire logic serialData,
  input wire logic loadEnable,
  // reference and feedback pins
  input wire logic referenceInput,
  input wire logic feedbackIn,
  // output mux pin
  output logic mux_output_select,
  output logic muxOutEn,
  // charge pump control
  output logic cpThreeState,
  output logic cpPolarity,
  output logic [3:0] cpCurrentCode,
  output logic cpBoost,
  output logic cpNoiseOpt,
  // synthesizer control
  output logic countersHeld,
  output logic powerDown,
  output logic ditherEn,
  output logic prescalerSel,
  output logic [8:0] intValue,
  output logic [11:0] fracValue,
  output logic [11:0] modulusActive,
  output logic comparisonPulse,
  output logic lockDetect
);

  // ****************************************
  // pin synchronisers
  // ****************************************
  logic [4:0] pinMeta_q;
  logic [4:0] pinSync_q;
  logic [4:0] pinLast_q;
  wire [4:0] pinIn = {feedbackIn, referenceInput, loadEnable, serialData, serialClk};

  genvar gi;
  generate
    for (gi = 0; gi < 5; gi++) begin : g_sync
      always_ff @(posedge clock) begin
        if (!rst_n) begin
          pinMeta_q[gi] <= 1'b0;
          pinSync_q[gi] <= 1'b0;
          pinLast_q[gi] <= 1'b0;
        end else begin
          pinMeta_q[gi] <= pinIn[gi];
          pinSync_q[gi] <= pinMeta_q[gi];
          pinLast_q[gi] <= pinSync_q[gi];
        end
      end
    end
  endgenerate

  wire sclkRise = pinSync_q[0] && !pinLast_q[0];
  wire sdataBit = pinSync_q[1];
  wire leRise = pinSync_q[2] && !pinLast_q[2];
  wire refRise = pinSync_q[3] && !pinLast_q[3];
  wire refFall = !pinSync_q[3] && pinLast_q[3];
  wire fbRise = pinSync_q[4] && !pinLast_q[4];

  // ****************************************
  // serial shift and register select
  // ****************************************
  logic [23:0] shiftReg_q;
  logic [23:0] feedbackDivReg_q;
  logic [23:0] refDividerReg_q;
  logic [23:0] controlReg_q;
  logic [23:0] noiseSpurReg_q;
  logic [11:0] modShadow_q;
  logic [11:0] flTimerValue_q;

  wire [1:0] selCode = shiftReg_q[1:0];
  wire wrFeedback = leRise && selCode == `SEL_FEEDBACK;
  wire wrRefDiv = leRise && selCode == `SEL_REFDIV;
  wire wrControl = leRise && selCode == `SEL_CONTROL;
  wire wrNoise = leRise && selCode == `SEL_NOISE;
  wire loadTimer = shiftReg_q[`RD_LOADCTL_BIT];
  wire [11:0] shiftMod = shiftReg_q[`RD_MOD_HI:`RD_MOD_LO];

  // writes are taken even in power-down; nothing here looks at it
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      shiftReg_q <= `WORD_RESET;
    end else if (sclkRise) begin
      shiftReg_q <= {shiftReg_q[22:0], sdataBit};
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      feedbackDivReg_q <= `WORD_RESET;
      refDividerReg_q <= `WORD_RESET;
      controlReg_q <= `WORD_RESET;
      noiseSpurReg_q <= `WORD_RESET;
      modShadow_q <= `MOD_RESET;
      flTimerValue_q <= `TIMER_RESET;
      modulusActive <= `MOD_RESET;
    end else begin
      if (wrFeedback) begin
        feedbackDivReg_q <= shiftReg_q;
        modulusActive <= modShadow_q;
      end
      if (wrRefDiv) begin
        refDividerReg_q <= shiftReg_q;
        if (loadTimer) begin
          flTimerValue_q <= shiftMod;
        end else begin
          modShadow_q <= shiftMod;
        end
      end
      if (wrControl) begin
        controlReg_q <= shiftReg_q;
      end
      if (wrNoise) begin
        noiseSpurReg_q <= shiftReg_q;
      end
    end
  end

  // ****************************************
  // decoded control fields
  // ****************************************
  wire ctlCntReset = controlReg_q[`CT_CNTRST_BIT];
  wire ctlPowerDown = controlReg_q[`CT_PWRDN_BIT];
  wire ctlDoubler = controlReg_q[`CT_DOUBLER_BIT];
  wire holdCounters = ctlCntReset || ctlPowerDown;
  wire [3:0] rValue = refDividerReg_q[`RD_RVAL_HI:`RD_RVAL_LO];
  wire [3:0] rEffective = (rValue == 4'h0) ? 4'h1 : rValue;
  wire [8:0] nsMode = noiseSpurReg_q[`NS_MODE_HI:`NS_MODE_LO];
  wire [2:0] muxSelRaw = refDividerReg_q[`RD_MUX_HI:`RD_MUX_LO];
  wire sdcr_pkg::sdcr_mux_e muxSel = sdcr_pkg::sdcr_mux_e'(muxSelRaw);

  // ****************************************
  // reference divider
  // ****************************************
  logic [3:0] rCount_q;
  logic rDivOut_q;
  wire refActive = ctlDoubler ? (refRise || refFall) : refFall;
  // >= so a lowered ratio wraps at once instead of running round to 15
  wire rWrap = refActive && (rCount_q >= rEffective - 4'h1);

  always_ff @(posedge clock) begin
    if (!rst_n || holdCounters) begin
      rCount_q <= 4'h0;
      rDivOut_q <= 1'b0;
      comparisonPulse <= 1'b0;
    end else begin
      comparisonPulse <= rWrap;
      if (rWrap) begin
        rCount_q <= 4'h0;
        rDivOut_q <= !rDivOut_q;
      end else if (refActive) begin
        rCount_q <= rCount_q + 4'h1;
      end
    end
  end

  // ****************************************
  // phase error measurement
  // ****************************************
  logic refPend_q;
  logic fbPend_q;
  logic [7:0] errCnt_q;
  logic errValid_q;
  logic [7:0] errSample_q;
  wire fbEvent = fbRise && !holdCounters;
  wire anyPend = refPend_q || fbPend_q;
  // a repeated edge on the same side counts as a worst-case error
  wire sameAgain = (refPend_q && comparisonPulse) || (fbPend_q && fbEvent);
  wire closes = (refPend_q && fbEvent) || (fbPend_q && comparisonPulse);

  always_ff @(posedge clock) begin
    if (!rst_n || holdCounters) begin
      refPend_q <= 1'b0;
      fbPend_q <= 1'b0;
      errCnt_q <= 8'h00;
      errValid_q <= 1'b0;
      errSample_q <= 8'h00;
    end else begin
      errValid_q <= 1'b0;
      if (comparisonPulse && fbEvent && !anyPend) begin
        errValid_q <= 1'b1;
        errSample_q <= 8'h00;
      end else if (closes) begin
        errValid_q <= 1'b1;
        errSample_q <= errCnt_q;
        refPend_q <= 1'b0;
        fbPend_q <= 1'b0;
      end else if (sameAgain) begin
        errValid_q <= 1'b1;
        errSample_q <= `ERR_MAX;
        errCnt_q <= 8'h01;
      end else if (!anyPend && (comparisonPulse || fbEvent)) begin
        refPend_q <= comparisonPulse;
        fbPend_q <= fbEvent;
        errCnt_q <= 8'h01;
      end else if (anyPend && errCnt_q != `ERR_MAX) begin
        errCnt_q <= errCnt_q + 8'h01;
      end
    end
  end

  // ****************************************
  // digital lock detect
  // ****************************************
  wire lockClear = holdCounters || wrFeedback;

  sdcr_lock_detect sdcr_lock_detect_inst (
    .clock(clock),
    .rst_n(rst_n),
    .clear(lockClear),
    .sampleValid(errValid_q),
    .errCycles(errSample_q),
    .precision(controlReg_q[`CT_LDP_BIT]),
    .locked(lockDetect)
  );

  // ****************************************
  // fast-lock timer
  // ****************************************
  sdcr_pkg::sdcr_fl_e flState_q;
  logic [11:0] flCount_q;
  wire flStart = wrFeedback && shiftReg_q[`FB_FASTLOCK_BIT] && flTimerValue_q != 12'h000;
  wire flLast = comparisonPulse && flCount_q == 12'h001;

  // counts comparison pulses, so it stalls under counter reset; power-down returns it to idle
  always_ff @(posedge clock) begin
    if (!rst_n || ctlPowerDown) begin
      flState_q <= sdcr_pkg::FL_IDLE;
      flCount_q <= 12'h000;
    end else if (flStart) begin
      flState_q <= sdcr_pkg::FL_RUN;
      flCount_q <= flTimerValue_q;
    end else begin
      unique case (flState_q)
        sdcr_pkg::FL_IDLE: begin
          flCount_q <= 12'h000;
        end
        sdcr_pkg::FL_RUN: begin
          if (flLast) begin
            flState_q <= sdcr_pkg::FL_IDLE;
          end
          if (comparisonPulse) begin
            flCount_q <= flCount_q - 12'h001;
          end
        end
      endcase
    end
  end

  wire flActive = flState_q == sdcr_pkg::FL_RUN;

  // ****************************************
  // output mux selection
  // ****************************************
  wire muxValue = (muxSel == sdcr_pkg::MUX_DIGITAL_LOCK) ? lockDetect :
                  (muxSel == sdcr_pkg::MUX_FEEDBACK_OUT) ? pinSync_q[4] :
                  (muxSel == sdcr_pkg::MUX_LOGIC_HIGH) ? 1'b1 :
                  (muxSel == sdcr_pkg::MUX_REFDIV_OUT) ? rDivOut_q :
                  (muxSel == sdcr_pkg::MUX_ANALOG_LOCK) ? 1'b0 : 1'b0;
  // analog lock is open drain: pull low only while unlocked
  wire muxDrive = (muxSel == sdcr_pkg::MUX_TRISTATE) ? 1'b0 :
                  (muxSel == sdcr_pkg::MUX_ANALOG_LOCK) ? !lockDetect :
                  (muxSel == sdcr_pkg::MUX_FASTLOCK_SW) ? flActive : 1'b1;

  // ****************************************
  // registered outputs
  // ****************************************
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      mux_output_select <= 1'b0;
      muxOutEn <= 1'b0;
      cpThreeState <= 1'b1;
      cpPolarity <= 1'b0;
      cpCurrentCode <= 4'h0;
      cpBoost <= 1'b0;
      cpNoiseOpt <= 1'b0;
      countersHeld <= 1'b1;
      powerDown <= 1'b0;
      ditherEn <= 1'b0;
      prescalerSel <= 1'b0;
      intValue <= 9'h000;
      fracValue <= 12'h000;
    end else begin
      mux_output_select <= muxValue;
      muxOutEn <= muxDrive;
      cpThreeState <= controlReg_q[`CT_TRISTATE_BIT] || ctlPowerDown;
      cpPolarity <= controlReg_q[`CT_POL_BIT];
      cpCurrentCode <= controlReg_q[`CT_CPI_HI:`CT_CPI_LO];
      cpBoost <= flActive;
      cpNoiseOpt <= nsMode == `NS_LOWEST_NOISE;
      countersHeld <= holdCounters;
      powerDown <= ctlPowerDown;
      ditherEn <= nsMode == `NS_LOWEST_SPUR;
      prescalerSel <= refDividerReg_q[`RD_PRESC_BIT];
      intValue <= feedbackDivReg_q[`FB_INT_HI:`FB_INT_LO];
      fracValue <= feedbackDivReg_q[`FB_FRACTION_VALUE_HI:`FB_FRACTION_VALUE_LO];
    end
  end

  // ****************************************
  // checks
  // ****************************************
  sequence s_refdiv_mod_write;
    wrRefDiv && !loadTimer;
  endsequence

  property p_modulus_shadow;
    @(posedge clock) disable iff (!rst_n)
    s_refdiv_mod_write ##1 !wrFeedback |-> modShadow_q == $past(shiftMod);
  endproperty
  a_modulus_shadow: assert property (p_modulus_shadow) else $error("modulus not shadowed");

  property p_timer_load;
    @(posedge clock) disable iff (!rst_n)
    wrRefDiv && loadTimer |=> flTimerValue_q == $past(shiftMod) && $stable(modShadow_q);
  endproperty
  a_timer_load: assert property (p_timer_load) else $error("timer load misrouted");

  property p_modulus_double_buffer;
    @(posedge clock) disable iff (!rst_n)
    !wrFeedback |=> $stable(modulusActive);
  endproperty
  a_modulus_double_buffer: assert property (p_modulus_double_buffer) else $error("modulus leaked");

  property p_noise_route;
    @(posedge clock) disable iff (!rst_n)
    wrNoise |=> noiseSpurReg_q == $past(shiftReg_q) ##1 ditherEn == (nsMode == `NS_LOWEST_SPUR);
  endproperty
  a_noise_route: assert property (p_noise_route) else $error("noise register misrouted");

  property p_control_route;
    @(posedge clock) disable iff (!rst_n)
    wrControl |=> ##1 cpCurrentCode == $past(shiftReg_q[`CT_CPI_HI:`CT_CPI_LO], 2);
  endproperty
  a_control_route: assert property (p_control_route) else $error("control code lost");

  sequence s_fast_start;
    flStart && !ctlPowerDown;
  endsequence

  property p_fast_boost;
    @(posedge clock) disable iff (!rst_n)
    s_fast_start ##1 !ctlPowerDown |=> cpBoost;
  endproperty
  a_fast_boost: assert property (p_fast_boost) else $error("boost missing");

  property p_fast_end;
    @(posedge clock) disable iff (!rst_n)
    flActive && flLast && !flStart |=> !flActive ##1 !cpBoost;
  endproperty
  a_fast_end: assert property (p_fast_end) else $error("fast lock overran");

  property p_powerdown_pump;
    @(posedge clock) disable iff (!rst_n)
    ctlPowerDown |=> cpThreeState && !flActive && !lockDetect;
  endproperty
  a_powerdown_pump: assert property (p_powerdown_pump) else $error("power-down not safe");

  property p_held_quiet;
    @(posedge clock) disable iff (!rst_n)
    holdCounters |=> rCount_q == 4'h0 && !comparisonPulse;
  endproperty
  a_held_quiet: assert property (p_held_quiet) else $error("counters ran in reset");

  property p_mux_fastlock;
    @(posedge clock) disable iff (!rst_n)
    muxSel == sdcr_pkg::MUX_FASTLOCK_SW && flActive |=> muxOutEn && !mux_output_select;
  endproperty
  a_mux_fastlock: assert property (p_mux_fastlock) else $error("switch not on mux pin");

endmodule

// ===== rtl/sdcr_params.svh
/*
  constants for the synthesizer divider control registers: field positions,
  register select codes, reset values and timing counts.
  assumes a 200 MHz system clock and 24-bit serial words.
*/
`ifndef SDCR_PARAMS_SVH
`define SDCR_PARAMS_SVH

// ****************************************
// serial word and register select
// ****************************************
`define WORD_BITS 24
`define SEL_FEEDBACK 2'h0
`define SEL_REFDIV 2'h1
`define SEL_CONTROL 2'h2
`define SEL_NOISE 2'h3
`define WORD_RESET 24'h000000

// ****************************************
// feedback divider word fields
// ****************************************
`define FB_FASTLOCK_BIT 23
`define FB_INT_HI 22
`define FB_INT_LO 14
`define FB_FRACTION_VALUE_HI 13
`define FB_FRACTION_VALUE_LO 2

// ****************************************
// reference divider word fields
// ****************************************
`define RD_LOADCTL_BIT 23
`define RD_MUX_HI 22
`define RD_MUX_LO 20
`define RD_PRESC_BIT 18
`define RD_RVAL_HI 17
`define RD_RVAL_LO 14
`define RD_MOD_HI 13
`define RD_MOD_LO 2
`define MOD_RESET 12'h000
`define TIMER_RESET 12'h000

// ****************************************
// control word fields
// ****************************************
`define CT_CNTRST_BIT 2
`define CT_TRISTATE_BIT 3
`define CT_PWRDN_BIT 4
`define CT_LDP_BIT 5
`define CT_POL_BIT 6
`define CT_CPI_HI 10
`define CT_CPI_LO 7
`define CT_DOUBLER_BIT 11

// ****************************************
// noise and spur word fields
// ****************************************
`define NS_MODE_HI 10
`define NS_MODE_LO 2
`define NS_LOWEST_SPUR 9'h000
`define NS_LOWEST_NOISE 9'h0f1

// ****************************************
// lock detect timing
// ****************************************
`define CLK_FREQ_MHZ 200
`define LD_GOOD_NS 15
`define LD_BAD_NS 30
`define LD_GOOD_CYC (`LD_GOOD_NS * `CLK_FREQ_MHZ / 1000)
`define LD_BAD_CYC (`LD_BAD_NS * `CLK_FREQ_MHZ / 1000)
`define LD_COUNT_LOW 6'd24
`define LD_COUNT_HIGH 6'd40
`define ERR_MAX 8'hff

`endif

// ===== rtl/sdcr_pkg.sv
/*
  types shared by the synthesizer divider control block.
  assumes nothing beyond a SystemVerilog compiler.
*/
package sdcr_pkg;

  // ****************************************
  // output mux selections
  // ****************************************
  typedef enum logic [2:0] {
    MUX_TRISTATE = 3'h0,
    MUX_DIGITAL_LOCK = 3'h1,
    MUX_FEEDBACK_OUT = 3'h2,
    MUX_LOGIC_HIGH = 3'h3,
    MUX_REFDIV_OUT = 3'h4,
    MUX_ANALOG_LOCK = 3'h5,
    MUX_FASTLOCK_SW = 3'h6,
    MUX_LOGIC_LOW = 3'h7
  } sdcr_mux_e;

  // ****************************************
  // fast-lock sequencer
  // ****************************************
  typedef enum logic {FL_IDLE, FL_RUN} sdcr_fl_e;

endpackage

// ===== rtl/sdcr_lock_detect.sv
/*
  digital lock detector: qualifies successive comparison cycles.
  assumes one sampleValid pulse per comparison cycle with its error in clocks.
*/
`timescale 1ns/1ps
`include "sdcr_params.svh"
module sdcr_lock_detect (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // measurement
  input wire logic clear,
  input wire logic sampleValid,
  input wire logic [7:0] errCycles,
  input wire logic precision,
  // result
  output logic locked
);

  logic [5:0] goodCnt_q;
  wire isGood = errCycles < 8'(`LD_GOOD_CYC);
  wire isBad = errCycles > 8'(`LD_BAD_CYC);
  wire [5:0] target = precision ? `LD_COUNT_HIGH : `LD_COUNT_LOW;
  wire [5:0] goodNext = goodCnt_q + 6'h01;

  always_ff @(posedge clock) begin
    if (!rst_n || clear) begin
      goodCnt_q <= 6'h00;
      locked <= 1'b0;
    end else if (sampleValid && locked) begin
      if (isBad) begin
        locked <= 1'b0;
      end
    end else if (sampleValid) begin
      // a middling error breaks the run without dropping lock
      goodCnt_q <= isGood ? goodNext : 6'h00;
      if (isGood && goodNext >= target) begin
        locked <= 1'b1;
        goodCnt_q <= 6'h00;
      end
    end
  end

  property p_lock_rise;
    @(posedge clock) disable iff (!rst_n)
    $rose(locked) |-> $past(goodCnt_q) == target - 6'h01 && $past(isGood);
  endproperty
  a_lock_rise: assert property (p_lock_rise) else $error("lock rose early");

  property p_lock_drop;
    @(posedge clock) disable iff (!rst_n)
    locked && sampleValid && isBad |=> !locked;
  endproperty
  a_lock_drop: assert property (p_lock_drop) else $error("lock held on bad error");

endmodule

// ===== tb/sdcr_host_model.sv
/*
  host model: drives the three-wire programming pins with 24-bit words.
  assumes a 200 MHz clock; each pin phase lasts 4 clocks.
*/
`timescale 1ns/1ps
module sdcr_host_model (
  // clock
  input wire logic clock,
  // programming pins
  output logic serialClk,
  output logic serialData,
  output logic loadEnable
);
  // ****************
  // word transfer
  // ****************
  initial begin
    serialClk = 1'b0;
    serialData = 1'b0;
    loadEnable = 1'b0;
  end
  // 4 clocks a phase, margin over the 3-clock pin sync
  task automatic ph;
    repeat (4) @(posedge clock);
    #1;
  endtask
  // msb first; low two bits pick the register
  task automatic sendWord(input logic [23:0] w);
    ph;
    for (int i = 23; i >= 0; i--) begin
      serialData = w[i];
      ph;
      serialClk = 1'b1;
      ph;
      serialClk = 1'b0;
    end
    loadEnable = 1'b1;
    ph;
    loadEnable = 1'b0;
    // released data line must not look held
    serialData = ~serialData;
    ph;
    ph;
  endtask
endmodule

// ===== tb/sdcr_control_regs_tb.sv
/*
  bench for the divider control registers: host model on the pins,
  bench-made reference and feedback; assumes a 200 MHz clock.
*/
`timescale 1ns/1ps
`include "sdcr_params.svh"
`define CHK(n, e, a) chk(n, 32'(e), 32'(a))
module sdcr_control_regs_tb;
  // ****************
  // signals
  // ****************
  logic clock, rst_n, serialClk, serialData, loadEnable, referenceInput, feedbackIn;
  logic mux_output_select, muxOutEn, cpThreeState, cpPolarity, cpBoost, cpNoiseOpt, countersHeld;
  logic powerDown, ditherEn, prescalerSel, comparisonPulse, lockDetect;
  logic [3:0] cpCurrentCode;
  logic [8:0] intValue;
  logic [11:0] fracValue, modulusActive;
  logic [15:0] fbHist = 16'h0000;
  int fbDelay, err_total, check_count, n;

  sdcr_control_regs sdcr_control_regs_inst (.clock, .rst_n, .serialClk, .serialData,
    .loadEnable, .referenceInput, .feedbackIn, .mux_output_select, .muxOutEn, .cpThreeState,
    .cpPolarity, .cpCurrentCode, .cpBoost, .cpNoiseOpt, .countersHeld, .powerDown,
    .ditherEn, .prescalerSel, .intValue, .fracValue, .modulusActive, .comparisonPulse,
    .lockDetect);
  sdcr_host_model sdcr_host_model_inst (.clock, .serialClk, .serialData, .loadEnable);

  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  // 20-clock reference; feedback rises on its falling edge, delayed on demand
  initial begin
    referenceInput = 1'b1;
    forever begin
      repeat (10) @(posedge clock);
      #1 referenceInput = ~referenceInput;
    end
  end
  always @(posedge clock) fbHist <= {fbHist[14:0], ~referenceInput};
  assign feedbackIn = fbHist[fbDelay];

  // ****************
  // tasks
  // ****************
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] a);
    check_count++;
    if (a !== e) begin
      err_total++;
      $display("wrong value %s expected %0h seen %0h", s, e, a);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic wr(input logic [23:0] w);
    sdcr_host_model_inst.sendWord(w);
    repeat (4) @(posedge clock);
    #1;
  endtask
  // reserved bits always zero
  task automatic ctl(input logic dbl, input logic [3:0] f);
    wr({12'h000, dbl, 4'ha, 1'b1, f, 2'b10});
  endtask
  task automatic rdv(input logic ld, input logic [2:0] m, input logic ps,
                     input logic [3:0] r, input logic [11:0] v);
    wr({ld, m, 1'b0, ps, r, v, 2'b01});
  endtask
  // integer 138 stays above both prescaler minimums
  task automatic nw(input logic fl);
    wr({fl, 9'd138, 12'd30, 2'b00});
  endtask
  task automatic ns(input logic [8:0] m);
    wr({13'h0000, m, 2'b11});
  endtask
  task automatic win(output int c);
    c = 0;
    repeat (400) begin
      @(posedge clock);
      #1;
      if (comparisonPulse === 1'b1) c++;
    end
  endtask
  task automatic waitLock(output int c);
    c = 0;
    while (lockDetect !== 1'b1 && c < 60) begin
      @(posedge clock);
      #1;
      if (comparisonPulse === 1'b1) c++;
    end
  endtask

  // ****************
  // tests
  // ****************
  initial begin
    rst_n = 1'b0;
    fbDelay = 0;
    err_total = 0;
    check_count = 0;
    repeat (16) @(posedge clock);
    #1;
    `CHK("threeState", 1'b1, cpThreeState);
    `CHK("held", 1'b1, countersHeld);
    `CHK("muxEn", 1'b0, muxOutEn);
    rst_n = 1'b1;
    ns(9'h000);
    `CHK("dither", 1'b1, ditherEn);
    ns(`NS_LOWEST_NOISE);
    `CHK("noiseOpt", 2'h1, {ditherEn, cpNoiseOpt});
    ns(9'h001);
    `CHK("midMode", 2'h0, {ditherEn, cpNoiseOpt});
    ctl(1'b0, 4'b0001);
    `CHK("cpCode", 4'ha, cpCurrentCode);
    `CHK("polarity", 1'b1, cpPolarity);
    `CHK("held", 1'b1, countersHeld);
    rdv(1'b0, 3'h3, 1'b1, 4'h1, 12'h041);
    `CHK("prescaler", 1'b1, prescalerSel);
    `CHK("muxHigh", 2'h3, {muxOutEn, mux_output_select});
    `CHK("modulus", 12'h000, modulusActive);
    nw(1'b0);
    `CHK("int", 9'd138, intValue);
    `CHK("fraction_value", 12'd30, fracValue);
    `CHK("modulus", 12'h041, modulusActive);
    ctl(1'b0, 4'b0000);
    `CHK("held", 1'b0, countersHeld);
    rdv(1'b0, 3'h7, 1'b1, 4'h1, 12'h041);
    `CHK("muxLow", 2'h2, {muxOutEn, mux_output_select});
    rdv(1'b0, 3'h0, 1'b1, 4'h1, 12'h041);
    `CHK("muxFloat", 1'b0, muxOutEn);
    win(n);
    `CHK("pulses", 1'b1, n >= 19 && n <= 21);
    ctl(1'b1, 4'b0000);
    win(n);
    `CHK("pulsesDbl", 1'b1, n >= 39 && n <= 41);
    ctl(1'b0, 4'b0000);
    rdv(1'b0, 3'h1, 1'b1, 4'h2, 12'h041);
    win(n);
    `CHK("pulsesR2", 1'b1, n >= 9 && n <= 11);
    rdv(1'b0, 3'h1, 1'b1, 4'h1, 12'h041);
    nw(1'b0);
    waitLock(n);
    `CHK("lock24", 1'b1, n >= `LD_COUNT_LOW - 1 && n <= `LD_COUNT_LOW + 2);
    // the mux pin is registered one clock behind the lock flag
    @(posedge clock);
    #1;
    `CHK("muxLock", 1'b1, mux_output_select);
    // 50 ns late feedback
    fbDelay = 10;
    repeat (60) @(posedge clock);
    #1;
    `CHK("lockLost", 1'b0, lockDetect);
    fbDelay = 0;
    ctl(1'b0, 4'b1000);
    nw(1'b0);
    waitLock(n);
    `CHK("lock40", 1'b1, n >= `LD_COUNT_HIGH - 1 && n <= `LD_COUNT_HIGH + 2);
    nw(1'b0);
    `CHK("newChannel", 1'b0, lockDetect);
    waitLock(n);
    ctl(1'b0, 4'b1100);
    `CHK("pd", 4'hf, {powerDown, cpThreeState, countersHeld, ~lockDetect});
    rdv(1'b0, 3'h1, 1'b0, 4'h1, 12'h041);
    `CHK("pdWrite", 1'b0, prescalerSel);
    ctl(1'b0, 4'b0000);
    `CHK("resume", 6'h0a, {powerDown, cpThreeState, cpCurrentCode});
    ctl(1'b0, 4'b0010);
    `CHK("float", 2'h2, {cpThreeState, countersHeld});
    ctl(1'b0, 4'b0000);
    rdv(1'b0, 3'h6, 1'b1, 4'h1, 12'h041);
    rdv(1'b1, 3'h6, 1'b1, 4'h1, 12'd5);
    nw(1'b1);
    `CHK("fastLock", 3'h6, {cpBoost, muxOutEn, mux_output_select});
    `CHK("modKept", 12'h041, modulusActive);
    n = 0;
    while (cpBoost === 1'b1 && n < 20) begin
      @(posedge clock);
      #1;
      if (comparisonPulse === 1'b1) n++;
    end
    `CHK("boostLen", 1'b1, n >= 4 && n <= 5);
    nw(1'b1);
    `CHK("boostAgain", 1'b1, cpBoost);
    report_and_stop;
  end

  // hang guard, well above the roughly 9k clocks the tests take
  initial begin
    repeat (60000) @(posedge clock);
    err_total++;
    report_and_stop;
  end
endmodule
